// ===== bst_defines.svh
// bst_defines.svh - shared constants of the boundary-scan test port
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

// ----------------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------------
`define BST_IR_W 4
`define BST_OP_EXTEST 4'h0
`define BST_OP_SAMPLE 4'h1
`define BST_OP_IDCODE 4'h2
`define BST_OP_CLAMP 4'h3
`define BST_OP_HIGHZ 4'h4
`define BST_OP_BYPASS 4'hf
`define BST_IR_CAPTURE 4'h1

// ----------------------------------------------------------------------------
// identity chain layout (version, part number, maker, fixed bit)
// ----------------------------------------------------------------------------
`define BST_ID_W 32
`define BST_ID_VER_W 4
`define BST_ID_PART_W 16
`define BST_ID_MAKER_W 11
`define BST_ID_FIXED 1'h1

// ----------------------------------------------------------------------------
// controller recovery length
// ----------------------------------------------------------------------------
`define BST_RESET_TMS_EDGES 5

`endif

// ===== bst_pkg.sv
// bst_pkg.sv - types of the boundary-scan test port
package bst_pkg;

    // ------------------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        TS_RESET, TS_IDLE,
        TS_SEL_DR, TS_CAP_DR, TS_SHIFT_DR, TS_EXIT1_DR, TS_PAUSE_DR, TS_EXIT2_DR, TS_UPD_DR,
        TS_SEL_IR, TS_CAP_IR, TS_SHIFT_IR, TS_EXIT1_IR, TS_PAUSE_IR, TS_EXIT2_IR, TS_UPD_IR
    } bst_state_e;

    // ------------------------------------------------------------------------
    // data register selection and pin override control
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {BST_SEL_CHAIN, BST_SEL_ID, BST_SEL_BYPASS} bst_dr_sel_e;

    typedef struct packed {
        logic force_en; // pad outputs taken from the boundary chain
        logic force_oe; // output enable while forced
    } bst_ctl_s;

endpackage

// ===== bst_sync.sv
// bst_sync.sv - two-flop level synchroniser
`timescale 1ns/1ns
module bst_sync #(
    parameter int W = 1
) (
    clk, // destination clock
    rst, // synchronous reset, destination domain
    d, // level from another domain
    q // synchronised level
);
    input wire logic clk;
    input wire logic rst;
    input wire logic [W-1:0] d;
    output logic [W-1:0] q;

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;
endmodule

// ===== bst_cell_pair.sv
// bst_cell_pair.sv - input and output boundary cells of one bidirectional pin
`timescale 1ns/1ns
module bst_cell_pair (
    tck, // test clock
    rst_tck, // reset in the test clock domain
    capture_en, // capture-dr with the chain selected
    shift_en, // shift-dr with the chain selected
    update_en, // update-dr with the chain selected
    scan_in, // serial data from the tdi side
    pin_level, // synchronised pin state
    drive_level, // synchronised value the device drives
    scan_out, // serial data toward tdo
    force_val // preloaded value for the pin
);
    input wire logic tck;
    input wire logic rst_tck;
    input wire logic capture_en;
    input wire logic shift_en;
    input wire logic update_en;
    input wire logic scan_in;
    input wire logic pin_level;
    input wire logic drive_level;
    output logic scan_out;
    output logic force_val;

    logic out_shift_reg;
    logic in_shift_reg;
    logic upd_reg;

    // output cell: captures the driven value, shifts
    always_ff @(posedge tck)
    begin
        if (rst_tck)
            out_shift_reg <= 1'h0;
        else if (capture_en)
            out_shift_reg <= drive_level; // R13
        else if (shift_en)
            out_shift_reg <= scan_in;
    end

    // input cell: observe only, no update stage
    always_ff @(posedge tck)
    begin
        if (rst_tck)
            in_shift_reg <= 1'h0;
        else if (capture_en)
            in_shift_reg <= pin_level; // R12
        else if (shift_en)
            in_shift_reg <= out_shift_reg; // R11
    end

    // output cell update stage, holds the value to force
    always_ff @(posedge tck)
    begin
        if (rst_tck)
            upd_reg <= 1'h0;
        else if (update_en)
            upd_reg <= out_shift_reg; // R13
    end

    assign scan_out = in_shift_reg;
    assign force_val = upd_reg;
endmodule

// ===== bst_tap.sv
// bst_tap.sv - boundary-scan test port: controller, instruction, data chains, pin muxing
// Operation
// R1 - controller is a sixteen-state synchronous machine covering both branches
// R2 - every transition follows the mode-select level at each rising test clock
// R3 - serial data enters the selected register from test data input
// R4 - selected register shifts out on test data output at test clock rate
// R5 - four registers: boundary chain, identity, bypass bit, instruction
// R6 - instruction and decode choose the operation and the data register
// R7 - decoder supports extest, sample/preload, idcode, bypass, clamp, highz
// R8 - identity holds version, part number, maker identity and fixed bit
// R9 - bypass register is exactly one bit, one clock of delay
// R10 - bypass connects input to output through the single bypass bit
// R11 - each bidirectional pin has one input and one output cell
// R12 - input cell only observes the pin, never forces internal logic
// R13 - output cell captures driven value and can force a preloaded one
// R14 - five rising edges with mode-select high reach test logic reset
// R15 - output changes on falling edges, driven only in shift states
`timescale 1ns/1ns
`include "bst_defines.svh"
module bst_tap #(
    parameter int NPINS = 8,
    parameter logic [`BST_ID_VER_W-1:0] ID_VERSION = 4'h1, // arbitrary value
    parameter logic [`BST_ID_PART_W-1:0] ID_PART = 16'h5a3c, // arbitrary value
    parameter logic [`BST_ID_MAKER_W-1:0] ID_MAKER = 11'h0a5 // arbitrary value
) (
    input wire logic mclk, // system clock
    input wire logic rst, // synchronous reset, active high
    input wire logic tck, // test clock from the tester
    input wire logic tms, // mode select, sampled on rising tck
    input wire logic tdi, // serial data in
    output logic tdo_o, // serial data out
    output logic tdo_oe, // serial data out enable
    input wire logic [NPINS-1:0] pin_i, // pad input level
    output logic [NPINS-1:0] pin_o, // pad output value
    output logic [NPINS-1:0] pin_oe, // pad output enable
    input wire logic [NPINS-1:0] core_out, // core value for the pads
    input wire logic [NPINS-1:0] core_oe, // core enable for the pads
    output logic [NPINS-1:0] core_in, // pad level toward the core
    output bst_pkg::bst_ctl_s test_ctl // pin override in force
);
    import bst_pkg::*;

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    // data register placed in the serial path by an instruction
    function automatic bst_dr_sel_e dr_select(input logic [`BST_IR_W-1:0] op);
        case (op)
            `BST_OP_EXTEST, `BST_OP_SAMPLE: dr_select = BST_SEL_CHAIN;
            `BST_OP_IDCODE: dr_select = BST_SEL_ID;
            default: dr_select = BST_SEL_BYPASS;
        endcase
    endfunction

    // pin override an instruction applies
    function automatic bst_ctl_s op_ctl(input logic [`BST_IR_W-1:0] op);
        case (op)
            `BST_OP_EXTEST, `BST_OP_CLAMP: op_ctl = '{force_en: 1'h1, force_oe: 1'h1};
            `BST_OP_HIGHZ: op_ctl = '{force_en: 1'h1, force_oe: 1'h0};
            default: op_ctl = '{force_en: 1'h0, force_oe: 1'h0};
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // test clock domain: reset and pin synchronisers
    // ------------------------------------------------------------------------
    logic rst_tck;
    logic [NPINS-1:0] pin_tck;
    logic [NPINS-1:0] drive_tck;
    logic [NPINS-1:0] pin_o_reg;
    logic [NPINS-1:0] pin_oe_reg;

    bst_sync #(.W(1)) u_rst_sync (.clk(tck), .rst(1'h0), .d(rst), .q(rst_tck));
    bst_sync #(.W(NPINS)) u_pin_sync (.clk(tck), .rst(rst_tck), .d(pin_i), .q(pin_tck));
    bst_sync #(.W(NPINS)) u_drv_sync (.clk(tck), .rst(rst_tck), .d(pin_o_reg), .q(drive_tck));

    // ------------------------------------------------------------------------
    // controller
    // ------------------------------------------------------------------------
    bst_state_e state_reg;
    bst_state_e state_next;

    // next state from the tms level
    always_comb
    begin
        case (state_reg)
            TS_RESET: state_next = tms ? TS_RESET : TS_IDLE; // R14
            TS_IDLE: state_next = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_DR: state_next = tms ? TS_SEL_IR : TS_CAP_DR;
            TS_CAP_DR: state_next = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_SHIFT_DR: state_next = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_EXIT1_DR: state_next = tms ? TS_UPD_DR : TS_PAUSE_DR;
            TS_PAUSE_DR: state_next = tms ? TS_EXIT2_DR : TS_PAUSE_DR;
            TS_EXIT2_DR: state_next = tms ? TS_UPD_DR : TS_SHIFT_DR;
            TS_UPD_DR: state_next = tms ? TS_SEL_DR : TS_IDLE;
            TS_SEL_IR: state_next = tms ? TS_RESET : TS_CAP_IR;
            TS_CAP_IR: state_next = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_SHIFT_IR: state_next = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_EXIT1_IR: state_next = tms ? TS_UPD_IR : TS_PAUSE_IR;
            TS_PAUSE_IR: state_next = tms ? TS_EXIT2_IR : TS_PAUSE_IR;
            TS_EXIT2_IR: state_next = tms ? TS_UPD_IR : TS_SHIFT_IR;
            TS_UPD_IR: state_next = tms ? TS_SEL_DR : TS_IDLE;
            default: state_next = TS_RESET;
        endcase
    end

    // state advances on every rising tck
    always_ff @(posedge tck)
    begin
        if (rst_tck)
            state_reg <= TS_RESET;
        else
            state_reg <= state_next; // R1 R2
    end

    // ------------------------------------------------------------------------
    // instruction register
    // ------------------------------------------------------------------------
    logic [`BST_IR_W-1:0] ir_shift_reg;
    logic [`BST_IR_W-1:0] ir_reg;
    bst_dr_sel_e dr_sel;

    // capture pattern, then shift from tdi
    always_ff @(posedge tck)
    begin
        if (rst_tck)
            ir_shift_reg <= `BST_IR_CAPTURE;
        else if (state_reg == TS_CAP_IR)
            ir_shift_reg <= `BST_IR_CAPTURE;
        else if (state_reg == TS_SHIFT_IR)
            ir_shift_reg <= {tdi, ir_shift_reg[`BST_IR_W-1:1]}; // R3
    end

    // active instruction, identity selected after reset
    always_ff @(posedge tck)
    begin
        if (rst_tck || state_reg == TS_RESET)
            ir_reg <= `BST_OP_IDCODE; // R8
        else if (state_reg == TS_UPD_IR)
            ir_reg <= ir_shift_reg; // R6
    end

    assign dr_sel = dr_select(ir_reg); // R6 R7

    // ------------------------------------------------------------------------
    // identity and bypass registers
    // ------------------------------------------------------------------------
    logic [`BST_ID_W-1:0] id_value;
    logic [`BST_ID_W-1:0] id_shift_reg;
    logic bypass_bit_reg;
    logic dr_cap;
    logic dr_shift;

    assign id_value = {ID_VERSION, ID_PART, ID_MAKER, `BST_ID_FIXED}; // R8
    assign dr_cap = (state_reg == TS_CAP_DR);
    assign dr_shift = (state_reg == TS_SHIFT_DR);

    // identity loads at capture and shifts lsb first
    always_ff @(posedge tck)
    begin
        if (rst_tck)
            id_shift_reg <= '0;
        else if (dr_cap && dr_sel == BST_SEL_ID)
            id_shift_reg <= id_value; // R8
        else if (dr_shift && dr_sel == BST_SEL_ID)
            id_shift_reg <= {tdi, id_shift_reg[`BST_ID_W-1:1]}; // R3 R5
    end

    // single bypass bit, captures zero
    always_ff @(posedge tck)
    begin
        if (rst_tck)
            bypass_bit_reg <= 1'h0;
        else if (dr_cap && dr_sel == BST_SEL_BYPASS)
            bypass_bit_reg <= 1'h0;
        else if (dr_shift && dr_sel == BST_SEL_BYPASS)
            bypass_bit_reg <= tdi; // R9 R10
    end

    // ------------------------------------------------------------------------
    // boundary cell chain, pin 0 nearest tdo
    // ------------------------------------------------------------------------
    logic [NPINS:0] chain;
    logic [NPINS-1:0] force_vals;
    logic chain_sel;

    assign chain_sel = (dr_sel == BST_SEL_CHAIN);
    assign chain[NPINS] = tdi;

    // two cells per pin
    generate
        for (genvar k = 0; k < NPINS; k++)
        begin : g_cell
            bst_cell_pair u_cell (
                .tck(tck),
                .rst_tck(rst_tck),
                .capture_en(dr_cap && chain_sel),
                .shift_en(dr_shift && chain_sel),
                .update_en(state_reg == TS_UPD_DR && chain_sel),
                .scan_in(chain[k+1]),
                .pin_level(pin_tck[k]),
                .drive_level(drive_tck[k]),
                .scan_out(chain[k]),
                .force_val(force_vals[k])
            ); // R5 R11
        end
    endgenerate

    // ------------------------------------------------------------------------
    // pin override state and its event toward mclk
    // ------------------------------------------------------------------------
    bst_ctl_s ctl_tck_reg;
    logic upd_tgl_reg;

    // override follows the active instruction
    always_ff @(posedge tck)
    begin
        if (rst_tck || state_reg == TS_RESET)
            ctl_tck_reg <= '0;
        else if (state_reg == TS_UPD_IR)
            ctl_tck_reg <= op_ctl(ir_shift_reg); // R7
    end

    // toggles on every update so mclk reloads the stable values
    always_ff @(posedge tck)
    begin
        if (rst_tck)
            upd_tgl_reg <= 1'h0;
        else if (state_reg == TS_UPD_IR || state_reg == TS_RESET || state_reg == TS_UPD_DR)
            upd_tgl_reg <= ~upd_tgl_reg;
    end

    // ------------------------------------------------------------------------
    // serial output on falling tck
    // ------------------------------------------------------------------------
    logic tdo_bit;
    logic is_shift;
    logic tdo_reg;
    logic tdo_oe_reg;

    assign is_shift = (state_reg == TS_SHIFT_DR) || (state_reg == TS_SHIFT_IR);

    // lsb of the register in the path
    always_comb
    begin
        if (state_reg == TS_SHIFT_IR)
            tdo_bit = ir_shift_reg[0];
        else if (dr_sel == BST_SEL_CHAIN)
            tdo_bit = chain[0];
        else if (dr_sel == BST_SEL_ID)
            tdo_bit = id_shift_reg[0];
        else
            tdo_bit = bypass_bit_reg; // R10
    end

    // driven only while shifting
    always_ff @(negedge tck)
    begin
        if (rst_tck)
        begin
            tdo_reg <= 1'h0;
            tdo_oe_reg <= 1'h0;
        end
        else
        begin
            tdo_reg <= tdo_bit; // R4 R15
            tdo_oe_reg <= is_shift; // R15
        end
    end

    assign tdo_o = tdo_reg;
    assign tdo_oe = tdo_oe_reg;

    // ------------------------------------------------------------------------
    // mclk domain: override reload and pad muxing
    // ------------------------------------------------------------------------
    logic tgl_m;
    logic tgl_seen_reg;
    bst_ctl_s ctl_m_reg;
    logic [NPINS-1:0] force_m_reg;

    bst_sync #(.W(1)) u_tgl_sync (.clk(mclk), .rst(rst), .d(upd_tgl_reg), .q(tgl_m));
    bst_sync #(.W(NPINS)) u_core_sync (.clk(mclk), .rst(rst), .d(pin_i), .q(core_in)); // R12

    // source values change only at a toggle and hold for many mclk cycles after it
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            tgl_seen_reg <= 1'h0;
            ctl_m_reg <= '0;
            force_m_reg <= '0;
        end
        else
        begin
            tgl_seen_reg <= tgl_m;
            if (tgl_m != tgl_seen_reg)
            begin
                ctl_m_reg <= ctl_tck_reg;
                force_m_reg <= force_vals;
            end
        end
    end

    // pads from the core or from the chain
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            pin_o_reg <= '0;
            pin_oe_reg <= '0;
        end
        else if (ctl_m_reg.force_en)
        begin
            pin_o_reg <= force_m_reg; // R13
            pin_oe_reg <= {NPINS{ctl_m_reg.force_oe}}; // R7
        end
        else
        begin
            pin_o_reg <= core_out;
            pin_oe_reg <= core_oe;
        end
    end

    assign pin_o = pin_o_reg;
    assign pin_oe = pin_oe_reg;
    assign test_ctl = ctl_m_reg;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    a_reset_five_high: assert property (@(posedge tck) disable iff (rst_tck) // R14
        tms [*5] |=> state_reg == TS_RESET)
        else $error("five tms highs did not reach reset");

    a_shift_dr_hold: assert property (@(posedge tck) disable iff (rst_tck) // R2
        state_reg == TS_SHIFT_DR |=> state_reg == ($past(tms) ? TS_EXIT1_DR : TS_SHIFT_DR))
        else $error("shift-dr left wrongly");

    a_update_to_idle: assert property (@(posedge tck) disable iff (rst_tck) // R1
        (state_reg == TS_UPD_DR || state_reg == TS_UPD_IR) && !tms |=> state_reg == TS_IDLE)
        else $error("update did not return to idle");

    a_ir_capture_pat: assert property (@(posedge tck) disable iff (rst_tck) // R6
        state_reg == TS_CAP_IR |=> ir_shift_reg == `BST_IR_CAPTURE)
        else $error("instruction capture pattern wrong");

    a_ir_idcode_reset: assert property (@(posedge tck) disable iff (rst_tck) // R8
        state_reg == TS_RESET |=> ir_reg == `BST_OP_IDCODE && !ctl_tck_reg.force_en)
        else $error("reset did not select identity");

    a_id_capture_val: assert property (@(posedge tck) disable iff (rst_tck) // R8
        dr_cap && dr_sel == BST_SEL_ID |=> id_shift_reg == id_value && id_shift_reg[0])
        else $error("identity capture wrong");

    a_id_shift_in: assert property (@(posedge tck) disable iff (rst_tck) // R3
        dr_shift && dr_sel == BST_SEL_ID |=> id_shift_reg[`BST_ID_W-1] == $past(tdi))
        else $error("identity did not take tdi");

    a_bypass_one_bit: assert property (@(posedge tck) disable iff (rst_tck) // R9
        dr_shift && dr_sel == BST_SEL_BYPASS ##1 dr_shift |-> tdo_bit == $past(tdi))
        else $error("bypass delay not one bit");

    a_tdo_float: assert property (@(posedge tck) disable iff (rst_tck) // R15
        state_reg != TS_SHIFT_DR && state_reg != TS_SHIFT_IR |-> !tdo_oe)
        else $error("tdo enable outside shift");

    a_highz_pins: assert property (@(posedge mclk) disable iff (rst) // R7
        ctl_m_reg.force_en && !ctl_m_reg.force_oe |=> pin_oe == '0)
        else $error("highz left pins driven");

    a_core_through: assert property (@(posedge mclk) disable iff (rst) // R13
        !ctl_m_reg.force_en |=> pin_o == $past(core_out) && pin_oe == $past(core_oe))
        else $error("core value not on pins");

    a_core_observe: assert property (@(posedge mclk) disable iff (rst) // R12
        $past(rst, 2) == 1'h0 |-> core_in == $past(pin_i, 2))
        else $error("core input not from pin");

    c_bypass_shift: cover property (@(posedge tck) dr_shift && dr_sel == BST_SEL_BYPASS);
    c_id_capture: cover property (@(posedge tck) dr_cap && dr_sel == BST_SEL_ID);
    c_extest_force: cover property (@(posedge mclk) ctl_m_reg.force_en && ctl_m_reg.force_oe);
    c_pause_ir: cover property (@(posedge tck) state_reg == TS_PAUSE_IR);
endmodule

// ===== bst_tester.sv
// bst_tester.sv - behavioural boundary-scan tester model
`timescale 1ns/1ns
module bst_tester (
    output logic tck, // test clock, still between frames
    output logic tms, // mode select
    output logic tdi, // serial data toward the port
    input wire logic tdo // serial data back, pulled up when released
);
    // ------------------------------------------
    // idle levels
    // ------------------------------------------
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one tck period: levels set while low, tdo taken before the rise
    task automatic step(input logic m, input logic b, output logic q);
        tms = m;
        tdi = b;
        #16;
        q = tdo;
        tck = 1'b1;
        #16;
        tck = 1'b0;
    endtask

    // tms high for n edges, then idle
    task automatic reset_tap(input int n);
        logic q;
        repeat (n) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask

    // from idle through one branch and back to idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi, q);
        if (ir)
            step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        repeat (3) step(1'b0, ~tdi, q); // settle time for the pin side
    endtask
endmodule

// ===== bst_tap_test.sv
// bst_tap_test.sv - self-checking bench of the boundary-scan test port
`timescale 1ns/1ns
`include "bst_defines.svh"
module bst_tap_test;
    import bst_pkg::*;
    localparam int NP = 8;
    localparam logic [3:0] VER = 4'h3; // arbitrary value
    localparam logic [15:0] PART = 16'h1e2d; // arbitrary value
    localparam logic [10:0] MAKER = 11'h13b; // arbitrary value
    logic mclk, rst, tck, tms, tdi, tdo_o, tdo_oe, tdo;
    logic [NP-1:0] pin_i, pin_o, pin_oe, core_out, core_oe, core_in;
    bst_ctl_s test_ctl;
    int err_count = 0;
    int cmp_count = 0;
    logic [31:0] d;
    logic [15:0] pre = 16'hc93a;

    assign tdo = tdo_oe ? tdo_o : 1'b1; // pull-up when released

    bst_tap #(.NPINS(NP), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER)) DUT (.mclk(mclk), .rst(rst),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .test_ctl(test_ctl));
    bst_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    // ------------------------------------------
    // clock, compare and verdict
    // ------------------------------------------
    initial
        mclk = 1'b0;
    always #2 mclk = ~mclk;

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic give_verdict();
        if (err_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------
    // scenarios
    // ------------------------------------------
    task automatic load_ir(input logic [3:0] op);
        tst.scan(1'b1, 4, {28'h0, op}, d);
        chk(d[3:0], `BST_IR_CAPTURE);
    endtask

    task automatic t_id();
        chk(tdo_oe, 1'b0);
        tst.scan(1'b0, 32, 32'h0, d);
        chk(d, {VER, PART, MAKER, `BST_ID_FIXED});
    endtask

    task automatic t_byp();
        logic [3:0] ops[2] = '{`BST_OP_BYPASS, 4'h9};
        foreach (ops[k])
        begin
            load_ir(ops[k]);
            tst.scan(1'b0, 8, 32'hb5, d);
            chk(d[7:0], 8'h6a);
        end
    endtask

    task automatic t_sample();
        load_ir(`BST_OP_SAMPLE);
        tst.scan(1'b0, 2 * NP, {16'h0, pre}, d);
        for (int k = 0; k < NP; k++)
        begin
            chk(d[2*k], pin_i[k]);
            chk(d[2*k+1], core_out[k]);
        end
        chk(pin_o, core_out);
        chk(pin_oe, core_oe);
        chk(core_in, pin_i);
    endtask

    task automatic t_force();
        logic [3:0] ops[3] = '{`BST_OP_EXTEST, `BST_OP_CLAMP, `BST_OP_HIGHZ};
        logic [NP-1:0] exp_o;
        for (int k = 0; k < NP; k++)
            exp_o[k] = pre[2*k+1];
        foreach (ops[k])
        begin
            load_ir(ops[k]);
            repeat (20) @(posedge mclk);
            #1;
            chk(pin_oe, (k < 2) ? {NP{1'b1}} : {NP{1'b0}});
            chk(test_ctl.force_oe, k < 2);
            if (k < 2)
            begin
                chk(pin_o, exp_o);
                chk(test_ctl.force_en, 1'b1);
            end
            chk(core_in, pin_i);
        end
        tst.reset_tap(5);
        repeat (20) @(posedge mclk);
        #1;
        chk(pin_o, core_out);
        chk(test_ctl.force_en, 1'b0);
    endtask

    // ------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------
    initial
    begin
        rst = 1'b1;
        pin_i = 8'h5c;
        core_out = 8'ha3;
        core_oe = 8'h96;
        fork
            begin
                repeat (16) @(posedge mclk);
                #1 rst = 1'b0;
            end
            tst.reset_tap(8);
        join
        t_id();
        t_byp();
        t_sample();
        t_force();
        give_verdict();
    end

    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule
